/* rdsl_btn_model.sv */
/*
 * Model of the reset push-button and the processor reset input.
 * Assumes press is set by the bench just after a sys_clk edge.
 */
`default_nettype none

module rdsl_btn_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic press,
  input wire logic cpu_reset_req,
  output logic rst_btn_n,
  output logic [7:0] reset_count
);
  timeunit 1ns;
  timeprecision 1ns;

  // ********
  // button
  // ********
  // contact to ground
  // open contact leaves the board pull-up in charge, so high
  assign rst_btn_n = press ? 1'b0 : 1'b1;

  // ********
  // processor
  // ********
  // reboots taken by the processor, one per pulse
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reset_count <= 8'h00;
    end else if (cpu_reset_req) begin
      reset_count <= reset_count + 8'h01;
    end
  end
endmodule : rdsl_btn_model

`default_nettype wire

/* rdsl_dbn_if.sv */
/*
 * Carrier between the top and the button debouncer.
 * Assumes both ends run on sys_clk.
 */
`default_nettype none

interface rdsl_dbn_if;
  logic btn_asserted;
  logic reset_req;

  // debouncer end
  modport dbn (
    input btn_asserted,
    output reset_req
  );

  // controller end
  modport ctl (
    output btn_asserted,
    input reset_req
  );
endinterface : rdsl_dbn_if

`default_nettype wire

/* rdsl_debounce.sv */
/*
 * Hold-time qualifier for the reset button; one pulse per press.
 * Assumes btn_asserted is already synchronised and filtered.
 */
`default_nettype none

module rdsl_debounce #(
  parameter int CNT_W = 24,
  parameter int DBN_CYCLES = rdsl_pkg::DBN_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  rdsl_dbn_if.dbn dbn
);

  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DBN_CYCLES - 1);

  logic [CNT_W-1:0] cnt_r;
  logic fired_r;
  logic req_r;
  logic cnt_done;

  assign cnt_done = (cnt_r == CNT_LAST);

  // ***************************************************
  // hold counter
  // ***************************************************
  // restart on release
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !dbn.btn_asserted) begin
      cnt_r <= '0;
    end else if (!fired_r && !cnt_done) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // single event per press
  // fired stays set until release so a long hold never repeats
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !dbn.btn_asserted) begin
      fired_r <= 1'b0;
    end else if (cnt_done) begin
      fired_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      req_r <= 1'b0;
    end else begin
      req_r <= dbn.btn_asserted && cnt_done && !fired_r;
    end
  end

  assign dbn.reset_req = req_r;

  // ***************************************************
  // checks
  // ***************************************************
  AST_CNT_CLEARS: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !dbn.btn_asserted |=> (cnt_r == '0) && !dbn.reset_req
  ) else $error("hold counter not cleared on release");

  AST_REQ_AFTER_HOLD: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    dbn.reset_req |-> ($past(cnt_r) == CNT_LAST) && $past(dbn.btn_asserted)
  ) else $error("request without full hold");

endmodule : rdsl_debounce

`default_nettype wire

/* rdsl_pkg.sv */
/*
 * Shared constants for the reset debounce and status LED block.
 * Assumes a single 100 MHz system clock and a synchronous reset.
 */
`default_nettype none

package rdsl_pkg;

  // ***************************************************
  // clock and timing
  // ***************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_MS = 1000000;
  // least hold time of the button before a reboot request
  localparam int DBN_TIME_MS = 125;
  localparam int DBN_CYCLES = (DBN_TIME_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // slow blink: full period in ms and half period in cycles
  localparam int BLINK_PERIOD_MS = 1000;
  localparam int BLINK_HALF_CYCLES = (BLINK_PERIOD_MS * NS_PER_MS / CLK_PERIOD_NS) / 2;

  // ***************************************************
  // pin input vector layout
  // ***************************************************
  localparam int PIN_W = 6;
  localparam int PIN_BTN_N = 0;
  localparam int PIN_RAIL = 1;
  localparam int PIN_SUST = 2;
  localparam int PIN_S0 = 3;
  localparam int PIN_SLEEP = 4;
  localparam int PIN_BOOT_FAIL = 5;
  // idle levels: button released (high), everything else inactive
  localparam logic [PIN_W-1:0] PIN_RST_VAL = 6'h01;

  // ***************************************************
  // output reset values
  // ***************************************************
  localparam logic LED_OFF = 1'b0;
  localparam logic PLED_N_RST = 1'b1;

  // green LED modes
  typedef enum logic [1:0] {
    RDSL_GRN_OFF,
    RDSL_GRN_ON,
    RDSL_GRN_BLINK
  } rdsl_grn_mode_t;

endpackage : rdsl_pkg

`default_nettype wire

/* rdsl_top.sv */
/*
 * Reset button debouncer and board status LED driver.
 * Assumes pins are asynchronous to sys_clk; software controls are
 * already on sys_clk.
 */
`default_nettype none

// What this block does
// - button pin low means pressed; a qualified press reboots the board.
// - accept a press only after 125 ms continuous hold.
// - issue one reset pulse per press; holding longer does nothing more.
// - green LED steady when all rails good in working state, else dark unless blinking in sleep.
// - green LED blinks slowly in sleep while sustain rail is good.
// - yellow LED lights on processor boot failure.
// - software can force the yellow LED on.
// - programmable LED output follows software, driven low to light.
module rdsl_top #(
  parameter int DBN_CYCLES = rdsl_pkg::DBN_CYCLES,
  parameter int BLINK_HALF_CYCLES = rdsl_pkg::BLINK_HALF_CYCLES,
  parameter int DBN_CNT_W = 24,
  parameter int BLINK_CNT_W = 26
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic rst_btn_n,
  input wire logic rails_good,
  input wire logic sustain_good,
  input wire logic state_working,
  input wire logic state_sleep,
  input wire logic boot_fail,
  input wire logic sw_fault_led_on,
  input wire logic sw_prog_led_on,
  output logic cpu_reset_req,
  output logic led_green,
  output logic led_yellow,
  output logic prog_led_n
);

  localparam logic [BLINK_CNT_W-1:0] BLINK_LAST = BLINK_CNT_W'(BLINK_HALF_CYCLES - 1);

  logic [rdsl_pkg::PIN_W-1:0] pin_vec;
  logic [rdsl_pkg::PIN_W-1:0] sync1_r;
  logic [rdsl_pkg::PIN_W-1:0] sync2_r;
  logic [rdsl_pkg::PIN_W-1:0] sync3_r;
  logic [rdsl_pkg::PIN_W-1:0] filt_r;
  logic [BLINK_CNT_W-1:0] blink_cnt_r;
  logic blink_r;
  rdsl_pkg::rdsl_grn_mode_t grn_mode;
  logic led_green_r;
  logic led_yellow_r;
  logic prog_led_n_r;
  logic f_rail;
  logic f_sust;
  logic f_s0;
  logic f_sleep;
  logic f_boot;

  rdsl_dbn_if dbn_bus ();

  assign pin_vec = {boot_fail, state_sleep, state_working, sustain_good, rails_good, rst_btn_n};

  // ***************************************************
  // pin synchronisers
  // ***************************************************
  // three stages per pin; a change is taken once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < rdsl_pkg::PIN_W; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          sync1_r[gi] <= rdsl_pkg::PIN_RST_VAL[gi];
          sync2_r[gi] <= rdsl_pkg::PIN_RST_VAL[gi];
          sync3_r[gi] <= rdsl_pkg::PIN_RST_VAL[gi];
          filt_r[gi] <= rdsl_pkg::PIN_RST_VAL[gi];
        end else begin
          sync1_r[gi] <= pin_vec[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
          if (sync2_r[gi] == sync3_r[gi]) begin
            filt_r[gi] <= sync3_r[gi];
          end
        end
      end
    end
  endgenerate

  assign f_rail = filt_r[rdsl_pkg::PIN_RAIL];
  assign f_sust = filt_r[rdsl_pkg::PIN_SUST];
  assign f_s0 = filt_r[rdsl_pkg::PIN_S0];
  assign f_sleep = filt_r[rdsl_pkg::PIN_SLEEP];
  assign f_boot = filt_r[rdsl_pkg::PIN_BOOT_FAIL];

  // ***************************************************
  // reset button
  // ***************************************************
  // low on the pin is a press
  assign dbn_bus.btn_asserted = !filt_r[rdsl_pkg::PIN_BTN_N];

  rdsl_debounce #(
    .CNT_W(DBN_CNT_W),
    .DBN_CYCLES(DBN_CYCLES)
  ) u_debounce (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .dbn(dbn_bus.dbn)
  );

  // edge event straight from the debouncer flop
  assign cpu_reset_req = dbn_bus.reset_req;

  // ***************************************************
  // blink divider
  // ***************************************************
  // half period count, toggle at wrap
  // free running so sleep entry may start mid-phase; blink rate is unaffected
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      blink_cnt_r <= '0;
      blink_r <= rdsl_pkg::LED_OFF;
    end else if (blink_cnt_r == BLINK_LAST) begin
      blink_cnt_r <= '0;
      blink_r <= !blink_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 1'b1;
    end
  end

  // ***************************************************
  // green LED
  // ***************************************************
  // working state with rail good wins over sleep if both inputs are ever seen at once
  always_comb begin
    if (f_s0 && f_rail) begin
      grn_mode = rdsl_pkg::RDSL_GRN_ON;
    end else if (f_sleep && f_sust) begin
      grn_mode = rdsl_pkg::RDSL_GRN_BLINK;
    end else begin
      grn_mode = rdsl_pkg::RDSL_GRN_OFF;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      led_green_r <= rdsl_pkg::LED_OFF;
    end else begin
      case (grn_mode)
        rdsl_pkg::RDSL_GRN_ON: begin
          led_green_r <= 1'b1;
        end
        rdsl_pkg::RDSL_GRN_BLINK: begin
          led_green_r <= blink_r;
        end
        default: begin
          led_green_r <= rdsl_pkg::LED_OFF;
        end
      endcase
    end
  end

  // ***************************************************
  // yellow and programmable LEDs
  // ***************************************************
  // boot fault lights yellow
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      led_yellow_r <= rdsl_pkg::LED_OFF;
    end else begin
      led_yellow_r <= f_boot || sw_fault_led_on;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prog_led_n_r <= rdsl_pkg::PLED_N_RST;
    end else begin
      prog_led_n_r <= !sw_prog_led_on;
    end
  end

  assign led_green = led_green_r;
  assign led_yellow = led_yellow_r;
  assign prog_led_n = prog_led_n_r;

  // ***************************************************
  // checks
  // ***************************************************
  AST_PRESS_IS_LOW: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    cpu_reset_req |-> !$past(filt_r[rdsl_pkg::PIN_BTN_N])
  ) else $error("reset request while button released");

  AST_ONE_PULSE: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    cpu_reset_req |=> !cpu_reset_req [*8]
  ) else $error("reset pulse repeated or stretched");

  AST_GREEN_STEADY: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (f_s0 && f_rail) [*2] |=> led_green
  ) else $error("green dark with rails good in working state");

  AST_GREEN_DARK: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (!f_rail && !(f_sleep && f_sust)) |=> !led_green
  ) else $error("green lit with rail out of limits");

  AST_GREEN_BLINK: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (f_sleep && f_sust && !(f_s0 && f_rail)) |=> (led_green == $past(blink_r))
  ) else $error("green not following blink in sleep");

  AST_BLINK_HALF: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    $changed(blink_r) |-> ($past(blink_cnt_r) == BLINK_LAST) && (blink_cnt_r == '0)
  ) else $error("blink toggled off its half period");

  AST_YELLOW_BOOT: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    f_boot |=> led_yellow
  ) else $error("yellow dark on boot fault");

  AST_YELLOW_SW: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (!f_boot && !sw_fault_led_on) |=> !led_yellow
  ) else $error("yellow lit without cause");

  AST_PLED_LOW: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    sw_prog_led_on |=> !prog_led_n
  ) else $error("programmable LED not driven low");

endmodule : rdsl_top

`default_nettype wire

/* reset_debounce_status_leds_test.sv */
/*
 * Self-checking bench for rdsl_top with a button/processor model.
 * Assumes shortened hold and blink counts set by parameter.
 */
`default_nettype none

module reset_debounce_status_leds_test;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int DBN = 20;
  localparam int HALF = 8;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic press = 1'b0;
  logic rails_good = 1'b0;
  logic sustain_good = 1'b0;
  logic state_working = 1'b0;
  logic state_sleep = 1'b0;
  logic boot_fail = 1'b0;
  logic sw_fault_led_on = 1'b0;
  logic sw_prog_led_on = 1'b0;
  logic rst_btn_n;
  logic cpu_reset_req;
  logic led_green;
  logic led_yellow;
  logic prog_led_n;
  logic [7:0] reset_count;
  int n_mismatch = 0;
  int check_count = 0;

  always #5 sys_clk = ~sys_clk;

  rdsl_top #(.DBN_CYCLES(DBN), .BLINK_HALF_CYCLES(HALF)) u_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .rst_btn_n(rst_btn_n),
    .rails_good(rails_good), .sustain_good(sustain_good),
    .state_working(state_working), .state_sleep(state_sleep),
    .boot_fail(boot_fail), .sw_fault_led_on(sw_fault_led_on),
    .sw_prog_led_on(sw_prog_led_on), .cpu_reset_req(cpu_reset_req),
    .led_green(led_green), .led_yellow(led_yellow), .prog_led_n(prog_led_n));

  rdsl_btn_model u_btn (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .press(press),
    .cpu_reset_req(cpu_reset_req), .rst_btn_n(rst_btn_n),
    .reset_count(reset_count));

  // ********
  // helpers
  // ********
  // inputs always move 1 ns after the edge, clear of sampling
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  task automatic check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_bit

  task automatic check_num(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_num

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic give_up();
    n_mismatch++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    conclude();
  endtask : give_up

  // cycles until led_green changes; bounded so a stuck LED ends the run
  task automatic wait_green(output int n);
    logic prev;
    prev = led_green;
    n = 0;
    while (led_green === prev) begin
      if (n > 3 * HALF) give_up();
      step(1);
      n++;
    end
  endtask : wait_green

  // ********
  // scenarios
  // ********
  task automatic sc_leds();
    int n;
    check_bit(prog_led_n, 1'b1);
    check_bit(led_green, 1'b0);
    sw_prog_led_on = 1'b1;
    step(2);
    check_bit(prog_led_n, 1'b0);
    sw_prog_led_on = 1'b0;
    boot_fail = 1'b1;
    step(8);
    check_bit(led_yellow, 1'b1);
    check_bit(prog_led_n, 1'b1);
    boot_fail = 1'b0;
    sw_fault_led_on = 1'b1;
    step(8);
    check_bit(led_yellow, 1'b1);
    sw_fault_led_on = 1'b0;
    step(2);
    check_bit(led_yellow, 1'b0);
    rails_good = 1'b1;
    state_working = 1'b1;
    sustain_good = 1'b1;
    step(8);
    check_bit(led_green, 1'b1);
    // working state with a rail down and no sleep input: dark
    rails_good = 1'b0;
    step(8);
    check_bit(led_green, 1'b0);
    // enter sleep; entry and the first toggle may cut a half period short
    state_working = 1'b0;
    state_sleep = 1'b1;
    wait_green(n);
    wait_green(n);
    wait_green(n);
    check_num(n[7:0], 8'(HALF));
    wait_green(n);
    check_num(n[7:0], 8'(HALF));
    sustain_good = 1'b0;
    step(8);
    check_bit(led_green, 1'b0);
    step(HALF);
    check_bit(led_green, 1'b0);
  endtask : sc_leds

  task automatic sc_bounce();
    // short presses with a brief gap
    press = 1'b1;
    step(DBN - 2);
    press = 1'b0;
    step(4);
    press = 1'b1;
    step(DBN - 2);
    press = 1'b0;
    step(DBN + 10);
    check_num(reset_count, 8'h00);
  endtask : sc_bounce

  task automatic sc_press(input logic [7:0] exp_count);
    int n;
    // operator holds well past the hold time
    press = 1'b1;
    n = 0;
    while (cpu_reset_req !== 1'b1) begin
      if (n > DBN + 10) give_up();
      step(1);
      n++;
    end
    check_bit(n >= DBN, 1'b1);
    check_bit(n <= DBN + 6, 1'b1);
    step(1);
    check_bit(cpu_reset_req, 1'b0);
    step(3 * DBN);
    check_num(reset_count, exp_count);
    press = 1'b0;
    step(10);
  endtask : sc_press

  // ********
  // main sequence
  // ********
  initial begin
    step(4);
    sys_rst = 1'b0;
    step(1);
    check_bit(cpu_reset_req, 1'b0);
    sc_leds();
    sc_bounce();
    sc_press(8'h01);
    sc_press(8'h02);
    conclude();
  end
endmodule : reset_debounce_status_leds_test

`default_nettype wire
